// file: rpl_defines.svh
// Purpose: Named constants for the remappable pin select block.
// Assumes: Included by the package and by the design modules.
// Notes: Offsets are byte addresses on the register port.
`ifndef RPL_DEFINES_SVH
`define RPL_DEFINES_SVH

// ==========================================================================
// Widths and counts
`define RPL_SEL_W 4
`define RPL_N_IN 15
`define RPL_N_OUT 33
`define RPL_N_SEL 48
`define RPL_IDX_W 6
`define RPL_N_PIN_IN 16
`define RPL_N_PERIPH 16
`define RPL_ADDR_W 16
`define RPL_DATA_W 32

// ==========================================================================
// Register offsets and fields
`define RPL_SYSCFG_OFS 16'hf000
`define RPL_LOCK_BIT 13
`define RPL_ONESHOT_BIT 29
`define RPL_SEL_OFS_LIST '{16'hfa04, 16'hfa08, 16'hfa0c, 16'hfa10, 16'hfa18, 16'hfa1c, \
   16'hfa20, 16'hfa24, 16'hfa28, 16'hfa2c, 16'hfa30, 16'hfa34, 16'hfa38, 16'hfa48, 16'hfa50, \
   16'hfb90, 16'hfbb4, 16'hfbb8, 16'hfbc0, 16'hfbc4, 16'hfbc8, 16'hfbcc, 16'hfbd0, 16'hfbd4, \
   16'hfbe0, 16'hfbe4, 16'hfbe8, 16'hfbec, 16'hfbf0, 16'hfbf8, 16'hfbfc, 16'hfc0c, 16'hfc14, \
   16'hfc20, 16'hfc24, 16'hfc40, 16'hfc44, 16'hfc48, 16'hfc4c, 16'hfc50, 16'hfc54, 16'hfc58, \
   16'hfc60, 16'hfc70, 16'hfc74, 16'hfc80, 16'hfc84, 16'hfc98}

// ==========================================================================
// Variant masks, one bit per select register index
`define RPL_ABSENT_64PIN 48'h7c06_7000_8000
`define RPL_ABSENT_USB 48'h0240_0000_0000
`define RPL_ABSENT_64PIN_USB 48'h0020_0000_0000
`define RPL_ALL_PRESENT 48'hffff_ffff_ffff

// ==========================================================================
// Reset values and timing
`define RPL_SEL_RESET 4'h0
`define RPL_NULL_SEL 4'h0
`define RPL_LOCK_RESET 1'b0
`define RPL_ONESHOT_RESET 1'b1
`define RPL_CAP_CYCLES 2'h2
`define RPL_WORD_ZERO 32'h0000_0000

`endif

// file: rpl_pkg.sv
// Purpose: Types shared by the pin select modules.
// Assumes: rpl_defines.svh supplies all widths except that of the two-bit capCnt.
// Notes: Each design module keeps its whole state in one struct from here.
`include "rpl_defines.svh"

package rpl_pkg;

   // =======================================================================
   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [`RPL_ADDR_W-1:0] addr;
      logic [`RPL_DATA_W-1:0] wdata;
   } rpl_bus_req_t;

   // =======================================================================
   // State of the select bank
   typedef struct packed {
      logic [`RPL_N_SEL-1:0][`RPL_SEL_W-1:0] mem;
      logic [`RPL_DATA_W-1:0] rdData;
   } rpl_bank_state_t;

   // =======================================================================
   // State of the top module
   typedef struct packed {
      logic lock;
      logic oneShot;
      logic capDone;
      logic [1:0] capCnt;
      logic cfgMeta;
      logic cfgSync;
      logic [`RPL_N_PIN_IN-1:0] pinInMeta;
      logic [`RPL_N_PIN_IN-1:0] pinInSync;
      logic [`RPL_N_IN-1:0] periphIn;
      logic [`RPL_N_OUT-1:0] pinOut;
      logic [`RPL_N_OUT-1:0] pinOutEn;
   } rpl_top_state_t;

endpackage

// file: rpl_sel_bank.sv
// Purpose: Storage for all four-bit select fields with a registered read port.
// Assumes: One write and one read per cycle at most, same clock as the top.
// Notes: The read register also carries a word supplied by the top.
`timescale 1ns/1ps
`include "rpl_defines.svh"

module rpl_sel_bank
   import rpl_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Write port
   input wire logic wrEn,
   input wire logic [`RPL_IDX_W-1:0] wrIdx,
   input wire logic [`RPL_SEL_W-1:0] wrData,
   // Read port
   input wire logic rdEn,
   input wire logic rdHit,
   input wire logic [`RPL_IDX_W-1:0] rdIdx,
   input wire logic [`RPL_DATA_W-1:0] altData,
   output logic [`RPL_DATA_W-1:0] rdData,
   // All fields in parallel for the routing logic
   output logic [`RPL_N_SEL*`RPL_SEL_W-1:0] selFlat
);
   import rpl_pkg::*;

   rpl_bank_state_t st_reg;
   rpl_bank_state_t st_next;

   // ========================================================================
   // Next state: one write, and read data that stand for one cycle only.
   always_comb
   begin
      st_next = st_reg;
      if (wrEn)
      begin
         st_next.mem[wrIdx] = wrData;
      end
      st_next.rdData = `RPL_WORD_ZERO;
      if (rdEn && rdHit)
      begin
         st_next.rdData = {{(`RPL_DATA_W-`RPL_SEL_W){1'b0}}, st_reg.mem[rdIdx]};
      end
      else if (rdEn)
      begin
         st_next.rdData = altData;
      end
   end

   // ========================================================================
   // Every field clears to the null selection at reset.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg.mem <= {`RPL_N_SEL{`RPL_SEL_RESET}};
         st_reg.rdData <= `RPL_WORD_ZERO;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign rdData = st_reg.rdData;
   assign selFlat = st_reg.mem;

endmodule // rpl_sel_bank

// file: rpl_pin_select.sv
// Purpose: Remappable pin select with a mapping write lock and one-shot option.
// Assumes: ref_clk at 40 MHz; pins and the boot word come from outside.
// Notes: Variant parameters remove registers that a package lacks.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "rpl_defines.svh"

module rpl_pin_select
   import rpl_pkg::*;
#(
   parameter bit PKG_64PIN = 1'b0,
   parameter bit HAS_USB = 1'b0
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire rpl_pkg::rpl_bus_req_t busReq,
   output logic [`RPL_DATA_W-1:0] busRdData,
   // System unlock state and boot configuration word three
   input wire logic sysUnlocked,
   input wire logic [`RPL_DATA_W-1:0] bootCfgWord3,
   // Remappable pins towards the peripheral inputs
   input wire logic [`RPL_N_PIN_IN-1:0] pinIn,
   output logic [`RPL_N_IN-1:0] periphIn,
   // Peripheral outputs towards the remappable pins
   input wire logic [`RPL_N_PERIPH-1:0] periphOut,
   output logic [`RPL_N_OUT-1:0] pinOut,
   output logic [`RPL_N_OUT-1:0] pinOutEn,
   // Status
   output logic mappingLocked
);
   import rpl_pkg::*;

   localparam logic [`RPL_ADDR_W-1:0] SEL_OFS [0:`RPL_N_SEL-1] = `RPL_SEL_OFS_LIST;

   // ========================================================================
   // Variant presence
   // Absent registers decode as unmapped, so they never store and read zero.
   localparam logic [`RPL_N_SEL-1:0] PRESENT = `RPL_ALL_PRESENT
      & ~(PKG_64PIN ? `RPL_ABSENT_64PIN : 48'h0)
      & ~(HAS_USB ? `RPL_ABSENT_USB : 48'h0)
      & ~((PKG_64PIN && HAS_USB) ? `RPL_ABSENT_64PIN_USB : 48'h0);

   rpl_top_state_t st_reg;
   rpl_top_state_t st_next;
   logic cfgHit;
   logic selHit;
   logic [`RPL_IDX_W-1:0] hitIdx;
   logic selWrEn;
   logic [`RPL_DATA_W-1:0] cfgRdWord;
   logic [`RPL_N_SEL*`RPL_SEL_W-1:0] selFlat;
   logic [`RPL_SEL_W-1:0] hitSel;
   logic [`RPL_SEL_W-1:0] firstOutSel;

   // ========================================================================
   // Address decode
   // The configuration register is checked first; the select table follows.
   always_comb
   begin
      cfgHit = 1'b0;
      selHit = 1'b0;
      hitIdx = '0;
      if (busReq.addr == `RPL_SYSCFG_OFS)
      begin
         cfgHit = 1'b1;
      end
      else
      begin
         for (int i = 0; i < `RPL_N_SEL; i++)
         begin
            if (busReq.addr == SEL_OFS[i] && PRESENT[i])
            begin
               selHit = 1'b1;
               hitIdx = i[`RPL_IDX_W-1:0];
            end
         end
      end
   end

   // Writes land only while the map is open; the bus never sees a refusal.
   assign selWrEn = busReq.wr && selHit && !st_reg.lock;

   // Only the lock bit is implemented in the configuration word.
   assign cfgRdWord = {{(`RPL_DATA_W-1){1'b0}}, st_reg.lock} << `RPL_LOCK_BIT;

   // ========================================================================
   // Select storage with registered read data
   rpl_sel_bank u_bank
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wrEn(selWrEn),
      .wrIdx(hitIdx),
      .wrData(busReq.wdata[`RPL_SEL_W-1:0]),
      .rdEn(busReq.rd),
      .rdHit(selHit),
      .rdIdx(hitIdx),
      .altData(cfgHit ? cfgRdWord : `RPL_WORD_ZERO),
      .rdData(busRdData),
      .selFlat(selFlat)
   );

   assign hitSel = selFlat[int'(hitIdx)*`RPL_SEL_W +: `RPL_SEL_W];
   assign firstOutSel = selFlat[`RPL_N_IN*`RPL_SEL_W +: `RPL_SEL_W];

   // ========================================================================
   // Next state: strap capture, lock control and routing.
   always_comb
   begin
      st_next = st_reg;

      // Boot word and pins are asynchronous, so two flops come first.
      st_next.cfgMeta = bootCfgWord3[`RPL_ONESHOT_BIT];
      st_next.cfgSync = st_reg.cfgMeta;
      st_next.pinInMeta = pinIn;
      st_next.pinInSync = st_reg.pinInMeta;

      // The one-shot option keeps its safe default until the strap settles.
      if (!st_reg.capDone)
      begin
         if (st_reg.capCnt == `RPL_CAP_CYCLES)
         begin
            st_next.oneShot = st_reg.cfgSync;
            st_next.capDone = 1'b1;
         end
         else
         begin
            st_next.capCnt = st_reg.capCnt + 2'h1;
         end
      end

      // Lock changes need the unlock state; one-shot refuses any clear.
      if (busReq.wr && cfgHit && sysUnlocked)
      begin
         if (busReq.wdata[`RPL_LOCK_BIT])
         begin
            st_next.lock = 1'b1;
         end
         else if (!(st_reg.oneShot && st_reg.lock))
         begin
            st_next.lock = 1'b0;
         end
      end

      // Each peripheral input follows the pin that its field names.
      for (int k = 0; k < `RPL_N_IN; k++)
      begin
         st_next.periphIn[k] = st_reg.pinInSync[selFlat[k*`RPL_SEL_W +: `RPL_SEL_W]];
      end

      // Each pin is driven by the chosen peripheral output, or released.
      for (int j = 0; j < `RPL_N_OUT; j++)
      begin
         if (selFlat[(`RPL_N_IN+j)*`RPL_SEL_W +: `RPL_SEL_W] == `RPL_NULL_SEL)
         begin
            st_next.pinOut[j] = 1'b0;
            st_next.pinOutEn[j] = 1'b0;
         end
         else
         begin
            st_next.pinOut[j] = periphOut[selFlat[(`RPL_N_IN+j)*`RPL_SEL_W +: `RPL_SEL_W]];
            st_next.pinOutEn[j] = 1'b1;
         end
      end
   end

   // ========================================================================
   // State register; a device reset clears the lock even in one-shot mode.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
         st_reg.lock <= `RPL_LOCK_RESET;
         st_reg.oneShot <= `RPL_ONESHOT_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ========================================================================
   // Outputs, all straight from flip-flops
   assign periphIn = st_reg.periphIn;
   assign pinOut = st_reg.pinOut;
   assign pinOutEn = st_reg.pinOutEn;
   assign mappingLocked = st_reg.lock;

   // ========================================================================
   // Checks
   default clocking cbDef @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence sCfgWrite;
      busReq.wr && cfgHit;
   endsequence

   // A lock set request that carries the unlock state.
   sequence sLockSetReq;
      busReq.wr && cfgHit && sysUnlocked && busReq.wdata[`RPL_LOCK_BIT];
   endsequence

   sequence sSelWriteOpen;
      busReq.wr && selHit && !st_reg.lock;
   endsequence

   sequence sSelWriteLocked;
      busReq.wr && selHit && st_reg.lock;
   endsequence

   AST_LOCK_BLOCKS_WRITE: assert property (sSelWriteLocked |=> $stable(selFlat))
      else $error("Select register changed while the mapping lock was set.");

   AST_OPEN_WRITE_TAKES: assert property (sSelWriteOpen |=>
      selFlat[int'($past(hitIdx))*`RPL_SEL_W +: `RPL_SEL_W] == $past(busReq.wdata[3:0]))
      else $error("Open select write was not stored.");

   AST_LOCK_SET_TAKES: assert property (sLockSetReq |=> st_reg.lock)
      else $error("Lock set by an unlocked write did not take.");

   AST_LOCK_NEEDS_UNLOCK: assert property ((sCfgWrite ##0 !sysUnlocked) |=>
      $stable(st_reg.lock))
      else $error("Lock changed without the unlock state.");

   AST_ONESHOT_HOLDS: assert property ((st_reg.oneShot && st_reg.lock) |=> st_reg.lock)
      else $error("One-shot lock was cleared.");

   AST_ONESHOT_DEFAULT: assert property (!st_reg.capDone |-> st_reg.oneShot)
      else $error("One-shot option lost its default before capture.");

   AST_SEL_READBACK: assert property ((busReq.rd && selHit) |=>
      busRdData == {28'h0, $past(hitSel)})
      else $error("Select read did not return the stored field.");

   AST_LOCK_READBACK: assert property ((busReq.rd && cfgHit) |=>
      busRdData[`RPL_LOCK_BIT] == $past(st_reg.lock))
      else $error("Configuration read did not show the lock.");

   AST_RD_ONE_CYCLE: assert property (!busReq.rd |=> busRdData == 32'h0)
      else $error("Read data stood outside the read cycle.");

   AST_ROUTE: assert property ((firstOutSel != `RPL_NULL_SEL) |=>
      pinOutEn[0] && pinOut[0] == $past(periphOut[firstOutSel]))
      else $error("Pin did not follow its chosen peripheral output.");

   AST_NULL_OUTPUT: assert property ((firstOutSel == `RPL_NULL_SEL) |=>
      !pinOutEn[0] && !pinOut[0])
      else $error("Null selection still drives its pin.");

endmodule // rpl_pin_select

// file: rpl_far_model.sv
// Purpose: Far side of the pin select: peripheral outputs and remappable pin levels.
// Assumes: Same clock as the block; pins are plain levels set by the bench.
// Notes: Peripheral outputs move every cycle so a stale route shows up.
`timescale 1ns/1ps

module rpl_far_model
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Pin levels wanted by the bench
   input wire logic [15:0] pinLevel,
   // Towards the block
   output logic [15:0] pinIn,
   output logic [15:0] periphOut
);
   // ======================================================================
   // Pins and peripherals
   logic [15:0] cntReg;

   // A running pattern; bit 0 stays low because select zero is the null output.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         cntReg <= 16'h0000;
      else
         cntReg <= cntReg + 16'h1235;
   end

   // Pins follow the bench directly.
   assign pinIn = pinLevel;
   assign periphOut = {cntReg[15:1], 1'b0};
endmodule // rpl_far_model

// file: test_remappable_pin_select_lock.sv
// Purpose: Self-checking bench for the pin select with its write lock.
// Assumes: Register port answers reads one cycle later; lock at bit 13.
// Notes: A second instance checks the 64-pin USB variant's holes.
`timescale 1ns/1ps

module test_remappable_pin_select_lock;
   import rpl_pkg::*;
   // ======================================================================
   // Signals
   logic ref_clk;
   logic rst_n;
   rpl_bus_req_t busReq;
   logic [31:0] busRdData, varRdData, rdVal, varVal, bootCfgWord3;
   logic sysUnlocked, mappingLocked;
   logic [15:0] pinLevel, pinIn, periphOut, periphOutQ;
   logic [14:0] periphIn;
   logic [32:0] pinOut, pinOutEn;
   int nFail, checksDone;

   // Clock of 25 ns.
   always #12.5 ref_clk = ~ref_clk;

   // Peripheral outputs as the block saw them at the last edge.
   always @(posedge ref_clk) periphOutQ <= periphOut;

   rpl_far_model u_far (.ref_clk(ref_clk), .rst_n(rst_n), .pinLevel(pinLevel),
      .pinIn(pinIn), .periphOut(periphOut));

   rpl_pin_select u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq),
      .busRdData(busRdData), .sysUnlocked(sysUnlocked), .bootCfgWord3(bootCfgWord3),
      .pinIn(pinIn), .periphIn(periphIn), .periphOut(periphOut), .pinOut(pinOut),
      .pinOutEn(pinOutEn), .mappingLocked(mappingLocked));

   // Variant with the smaller package and the USB module.
   rpl_pin_select #(.PKG_64PIN(1'b1), .HAS_USB(1'b1)) u_var (.ref_clk(ref_clk),
      .rst_n(rst_n), .busReq(busReq), .busRdData(varRdData), .sysUnlocked(sysUnlocked),
      .bootCfgWord3(bootCfgWord3), .pinIn(pinIn), .periphIn(), .periphOut(periphOut),
      .pinOut(), .pinOutEn(), .mappingLocked());

   // ======================================================================
   // Helpers
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checksDone++;
      if (got !== exp)
      begin
         $display("BAD %s exp %h got %h", what, exp, got);
         nFail++;
      end
   endtask

   // One more edge passes so that the write's effect has settled on return.
   task automatic wr(logic [15:0] a, logic [31:0] d);
      @(posedge ref_clk);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      busReq <= '0;
      @(posedge ref_clk);
   endtask

   // Read data stand only in the cycle after the strobe, so take them there.
   task automatic rd(logic [15:0] a);
      @(posedge ref_clk);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge ref_clk);
      busReq <= '0;
      #1;
      rdVal = busRdData;
      varVal = varRdData;
   endtask

   // Reset long enough, then let the boot option be captured.
   task automatic do_reset();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic testDone();
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_reset();
      chk("locked", 32'h0, {31'h0, mappingLocked});
      chk("pinOutEn", 32'h0, pinOutEn[31:0]);
      rd(16'hfa04);
      chk("in sel reset", 32'h0, rdVal);
      rd(16'hfc98);
      chk("out sel reset", 32'h0, rdVal);
      $display("test reset done");
   endtask

   task automatic t_route();
      wr(16'hfbb4, 32'hffff_fff5);
      rd(16'hfbb4);
      chk("sel field", 32'h5, rdVal);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("pin drive", 32'h1, {31'h0, pinOutEn[1]});
      chk("pin level", {31'h0, periphOutQ[5]}, {31'h0, pinOut[1]});
      wr(16'hfa04, 32'h3);
      pinLevel <= 16'h0008;
      repeat (4) @(posedge ref_clk);
      #1;
      chk("in route hi", 32'h1, {31'h0, periphIn[0]});
      pinLevel <= 16'hfff7;
      repeat (4) @(posedge ref_clk);
      #1;
      chk("in route lo", 32'h0, {31'h0, periphIn[0]});
      $display("test route done");
   endtask

   task automatic t_lock();
      sysUnlocked <= 1'b0;
      wr(16'hf000, 32'h2000);
      chk("lock w/o unlock", 32'h0, {31'h0, mappingLocked});
      sysUnlocked <= 1'b1;
      wr(16'hf000, 32'h2000);
      chk("lock set", 32'h1, {31'h0, mappingLocked});
      rd(16'hf000);
      chk("cfg read", 32'h2000, rdVal);
      wr(16'hfbb4, 32'h9);
      rd(16'hfbb4);
      chk("locked write", 32'h5, rdVal);
      chk("locked read", 32'h5, rdVal);
      wr(16'hf000, 32'h0);
      chk("lock clear", 32'h0, {31'h0, mappingLocked});
      wr(16'hfbb4, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("null out", 32'h0, {31'h0, pinOutEn[1]});
      @(posedge ref_clk);
      sysUnlocked <= 1'b0;
      $display("test lock done");
   endtask

   // Erased boot word: the one-shot option is on.
   task automatic t_oneshot();
      bootCfgWord3 <= 32'hffff_ffff;
      do_reset();
      sysUnlocked <= 1'b1;
      wr(16'hf000, 32'h2000);
      wr(16'hf000, 32'h0);
      chk("one-shot hold", 32'h1, {31'h0, mappingLocked});
      wr(16'hfbb4, 32'h7);
      rd(16'hfbb4);
      chk("one-shot sel", 32'h0, rdVal);
      do_reset();
      chk("reset clears", 32'h0, {31'h0, mappingLocked});
      wr(16'hfbb4, 32'h7);
      rd(16'hfbb4);
      chk("reopened", 32'h7, rdVal);
      $display("test oneshot done");
   endtask

   // Holes of the small USB variant against the full device.
   task automatic t_variant();
      logic [15:0] ofs [5] = '{16'hfb90, 16'hfc48, 16'hfc4c, 16'hfbb4, 16'hfc9c};
      logic [31:0] vExp [5] = '{32'h0, 32'h0, 32'h0, 32'h3, 32'h0};
      logic [31:0] dExp [5] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h0};
      for (int i = 0; i < 5; i++)
      begin
         wr(ofs[i], 32'h3);
         rd(ofs[i]);
         chk("variant", vExp[i], varVal);
         chk("full", dExp[i], rdVal);
      end
      $display("test variant done");
   endtask

   // ======================================================================
   // Main sequence
   initial
   begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      busReq = '0;
      sysUnlocked = 1'b0;
      bootCfgWord3 = 32'h0000_0000;
      pinLevel = 16'h0000;
      nFail = 0;
      checksDone = 0;
      do_reset();
      t_reset();
      t_route();
      t_lock();
      t_oneshot();
      t_variant();
      testDone();
   end

   // Watchdog well beyond the roughly 120 cycles the tests need.
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      nFail++;
      testDone();
   end
endmodule // test_remappable_pin_select_lock
